// file: pkg/lpsc_defines.svh
/*
 Register offsets, field positions, reset values and timing counts
 of the light and proximity sensor control block.
 Assumes inclusion by bare name from design files.
*/
`ifndef LPSC_DEFINES_SVH
`define LPSC_DEFINES_SVH
`define LPSC_OFF_SYSCTL 8'h40
`define LPSC_OFF_MODE 8'h41
`define LPSC_OFF_GAIN 8'h42
`define LPSC_OFF_PXCTL 8'h43
`define LPSC_OFF_PX_LO 8'h44
`define LPSC_OFF_PX_HI 8'h45
`define LPSC_OFF_VIS_LO 8'h46
`define LPSC_OFF_VIS_HI 8'h47
`define LPSC_OFF_IR_LO 8'h48
`define LPSC_OFF_IR_HI 8'h49
`define LPSC_OFF_INTREG 8'h4A
`define LPSC_BIT_RESTART 7
`define LPSC_BIT_ALERT_REL 6
`define LPSC_BIT_LIGHT_ON 7
`define LPSC_BIT_PROX_ON 6
`define LPSC_BIT_PULSE 5
`define LPSC_BIT_TWICE 4
`define LPSC_RST_MODE 8'h00
`define LPSC_RST_GAIN 8'h02
`define LPSC_RST_PXCTL 6'h01
`define LPSC_RESTART_CYCLES 16
`define LPSC_PULSE_SHORT_US 200
`define LPSC_PULSE_LONG_US 330
`define LPSC_CLK_MHZ 125
`define LPSC_PULSE_SHORT_CYC (`LPSC_PULSE_SHORT_US * `LPSC_CLK_MHZ)
`define LPSC_PULSE_LONG_CYC (`LPSC_PULSE_LONG_US * `LPSC_CLK_MHZ)
`define LPSC_MS_CYC (1000 * `LPSC_CLK_MHZ)
`endif

// file: pkg/lpsc_pkg.sv
/*
 Types of the light and proximity sensor control block.
 Assumes no surroundings beyond a SystemVerilog compiler.
*/
package lpsc_pkg;
   typedef enum logic [3:0] {
      LPSC_IDLE = 4'b0001,
      LPSC_EMIT = 4'b0010,
      LPSC_WAIT = 4'b0100,
      LPSC_RSTG = 4'b1000
   } lpsc_state_e;
   typedef struct packed {
      logic we;
      logic re;
      logic [7:0] addr;
      logic [7:0] wdata;
   } lpsc_req_s;
   typedef struct packed {
      logic [15:0] visible;
      logic [15:0] infrared;
      logic [11:0] proximity;
      logic [1:0] amb_ir;
   } lpsc_meas_s;
endpackage

// file: rtl/lpsc_period_rom.sv
/*
 Period table: maps a period code to light and proximity periods
 in milliseconds, registered output. Assumes the caller holds the
 code stable; forbidden codes give standby.
*/
`timescale 1ns/1ps
`default_nettype none
module lpsc_period_rom
   import lpsc_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [3:0] code,
   output logic [9:0] light_ms,
   output logic [9:0] prox_ms,
   output logic light_sleep,
   output logic light_hisens
);
   always_ff @(posedge core_clk) begin
      if (rst) begin
         light_ms <= 10'h000;
         prox_ms <= 10'h000;
         light_sleep <= 1'b0;
         light_hisens <= 1'b0;
      end else begin
         light_sleep <= (code == 4'h8) || (code == 4'h9);
         light_hisens <= (code == 4'hA);
         unique case (code)
            4'h0: begin light_ms <= 10'd0; prox_ms <= 10'd0; end
            4'h1: begin light_ms <= 10'd0; prox_ms <= 10'd10; end
            4'h2: begin light_ms <= 10'd0; prox_ms <= 10'd40; end
            4'h3: begin light_ms <= 10'd0; prox_ms <= 10'd100; end
            4'h4: begin light_ms <= 10'd0; prox_ms <= 10'd400; end
            4'h5: begin light_ms <= 10'd100; prox_ms <= 10'd50; end
            4'h6: begin light_ms <= 10'd100; prox_ms <= 10'd100; end
            4'h7: begin light_ms <= 10'd100; prox_ms <= 10'd400; end
            4'h8: begin light_ms <= 10'd400; prox_ms <= 10'd50; end
            4'h9: begin light_ms <= 10'd400; prox_ms <= 10'd100; end
            4'hA: begin light_ms <= 10'd400; prox_ms <= 10'd0; end
            4'hB: begin light_ms <= 10'd400; prox_ms <= 10'd400; end
            4'hC: begin light_ms <= 10'd50; prox_ms <= 10'd50; end
            default: begin light_ms <= 10'd0; prox_ms <= 10'd0; end
         endcase
      end
   end
endmodule
`default_nettype wire

// file: rtl/lpsc_ctrl.sv
/*
 Control and result registers of a light and proximity sensor.
// Notes on behaviour
// R1: writing one to restart bit restarts device
// R2: alert release bit frees alert pin
// R3: mode bits 7,6 enable light, proximity
// R4: pulse bit picks 200us or 330us, doubles
// R5: mode bit 4 selects twice measurement
// R6: period code sets periods; 1101-1111 forbidden
// R7: codes 1000,1001: light 100ms, sleep 300ms
// R8: 1010 high sensitivity light; 1011 both 400ms
// R9: host runs extra procedure for 1100
// R10: gain bits 5:4 set visible gain
// R11: gain bits 3:2 set infrared gain
// R12: gain bits 1:0 set emitter current
// R13: proximity control 7:6 report ambient infrared
// R14: proximity gain bits 5:4; 11 forbidden
// R15: persistence 0000 asserts, 0001 refreshes each end
// R16: persistence N needs N agreeing judgments
// R17: persistence filters proximity only
// R18: alert freed by interrupt read, restart
// R19: proximity result twelve bits, high nibble zero
// R20: light results sixteen bits, low, high byte
 Assumes an I2C slave front end giving byte register requests and
 analog front ends delivering measurements with a done strobe and a
 threshold judgment.
*/
`timescale 1ns/1ps
`default_nettype none
`include "lpsc_defines.svh"
module lpsc_ctrl
   import lpsc_pkg::*;
#(
   parameter int RESTART_CYCLES = `LPSC_RESTART_CYCLES,
   parameter int PULSE_SHORT_CYC = `LPSC_PULSE_SHORT_CYC,
   parameter int PULSE_LONG_CYC = `LPSC_PULSE_LONG_CYC,
   parameter logic [5:0] PART_ID = 6'h15
)(
   input wire logic core_clk,
   input wire logic rst,
   input wire lpsc_req_s req,
   output logic [7:0] rdata_ff,
   input wire lpsc_meas_s meas,
   input wire logic prox_done,
   input wire logic prox_judge,
   input wire logic light_done,
   input wire logic light_judge,
   output logic alert_oe,
   output logic emitter_oe,
   output logic emitter_out,
   output logic light_sensing_on,
   output logic proximity_sensing_on,
   output logic twice_mode,
   output logic [9:0] light_period_ms,
   output logic [9:0] prox_period_ms,
   output logic light_sleep_phase,
   output logic light_high_sens,
   output logic [1:0] visible_channel_gain,
   output logic [1:0] infrared_channel_gain,
   output logic [1:0] emitter_drive_level,
   output logic [1:0] proximity_gain,
   output logic restarting
);
   // PART_ID value is arbitrary
   // counts must fit the 16-bit sequencer counter
   if (RESTART_CYCLES < 1 || PULSE_SHORT_CYC < 1
       || PULSE_LONG_CYC < PULSE_SHORT_CYC || PULSE_LONG_CYC > 65535
       || RESTART_CYCLES > 65535) begin : g_bad_timing
      $error("lpsc_ctrl: bad timing parameters");
   end

   logic [7:0] mode_ff;
   logic [7:0] gain_ff;
   logic [5:0] pxctl_ff;
   logic alert_rel_ff;
   logic prox_int_ff;
   logic light_int_ff;
   logic [3:0] agree_cnt_ff;
   logic last_judge_ff;
   logic [11:0] px_ff;
   logic [15:0] vis_ff;
   logic [15:0] ir_ff;
   logic [1:0] amb_ff;
   logic [15:0] cnt_ff;
   lpsc_state_e state_ff;
   logic restart_req;
   logic intreg_read;
   logic wr;
   logic [3:0] agree_next;

   assign wr = req.we;
   // R1: restart on one
   assign restart_req = wr && req.addr == `LPSC_OFF_SYSCTL
                        && req.wdata[`LPSC_BIT_RESTART];
   assign intreg_read = req.re && req.addr == `LPSC_OFF_INTREG;
   assign restarting = (state_ff == LPSC_RSTG);

   always_ff @(posedge core_clk) begin
      if (rst || restart_req || restarting) begin
         mode_ff <= `LPSC_RST_MODE;
         gain_ff <= `LPSC_RST_GAIN;
         pxctl_ff <= `LPSC_RST_PXCTL;
      end else if (wr) begin
         if (req.addr == `LPSC_OFF_MODE)
            mode_ff <= req.wdata;
         if (req.addr == `LPSC_OFF_GAIN)
            gain_ff <= req.wdata;
         // R14: proximity gain stored
         if (req.addr == `LPSC_OFF_PXCTL)
            pxctl_ff <= req.wdata[5:0];
      end
   end

   // R3: channel enables
   assign light_sensing_on = mode_ff[`LPSC_BIT_LIGHT_ON];
   assign proximity_sensing_on = mode_ff[`LPSC_BIT_PROX_ON];
   // R5: twice measurement
   assign twice_mode = mode_ff[`LPSC_BIT_TWICE];
   // R10: visible gain
   assign visible_channel_gain = gain_ff[5:4];
   // R11: infrared gain
   assign infrared_channel_gain = gain_ff[3:2];
   // R12: emitter current
   assign emitter_drive_level = gain_ff[1:0];
   assign proximity_gain = pxctl_ff[5:4];

   // R6: period table lookup
   lpsc_period_rom u_rom (
      .core_clk(core_clk),
      .rst(rst),
      .code(mode_ff[3:0]),
      .light_ms(light_period_ms),
      .prox_ms(prox_period_ms),
      // R7: sleep after 100ms
      .light_sleep(light_sleep_phase),
      // R8: high sensitivity code
      .light_hisens(light_high_sens)
   );

   // emitter pulse sequencer and restart sequence
   always_ff @(posedge core_clk) begin
      if (rst) begin
         state_ff <= LPSC_IDLE;
         cnt_ff <= 16'h0000;
      end else if (restart_req) begin
         state_ff <= LPSC_RSTG;
         cnt_ff <= 16'(RESTART_CYCLES - 1);
      end else begin
         unique case (state_ff)
            LPSC_IDLE: begin
               if (proximity_sensing_on && prox_period_ms != 10'h000) begin
                  state_ff <= LPSC_EMIT;
                  // R4: pulse width select
                  cnt_ff <= mode_ff[`LPSC_BIT_PULSE]
                     ? 16'(PULSE_LONG_CYC - 1) : 16'(PULSE_SHORT_CYC - 1);
               end
            end
            LPSC_EMIT: begin
               if (cnt_ff == 16'h0000)
                  state_ff <= LPSC_WAIT;
               else
                  cnt_ff <= cnt_ff - 16'h0001;
            end
            LPSC_WAIT: begin
               if (prox_done || !proximity_sensing_on)
                  state_ff <= LPSC_IDLE;
            end
            LPSC_RSTG: begin
               if (cnt_ff == 16'h0000)
                  state_ff <= LPSC_IDLE;
               else
                  cnt_ff <= cnt_ff - 16'h0001;
            end
         endcase
      end
   end
   assign emitter_oe = (state_ff == LPSC_EMIT);
   assign emitter_out = 1'b0;

   // measurement capture
   always_ff @(posedge core_clk) begin
      if (rst || restarting) begin
         px_ff <= 12'h000;
         vis_ff <= 16'h0000;
         ir_ff <= 16'h0000;
         amb_ff <= 2'b00;
      end else begin
         if (prox_done) begin
            // R4: long pulse doubles output
            px_ff <= mode_ff[`LPSC_BIT_PULSE]
               ? {meas.proximity[10:0], 1'b0} : meas.proximity;
            // R13: ambient infrared flag
            amb_ff <= meas.amb_ir;
         end
         if (light_done) begin
            vis_ff <= meas.visible;
            ir_ff <= meas.infrared;
         end
      end
   end

   // saturates so a long agreeing run keeps refreshing the status
   assign agree_next = (prox_judge != last_judge_ff) ? 4'h1
                       : (agree_cnt_ff == 4'hF) ? 4'hF
                       : agree_cnt_ff + 4'h1;

   // R16: agreement counter
   always_ff @(posedge core_clk) begin
      if (rst || restarting) begin
         agree_cnt_ff <= 4'h0;
         last_judge_ff <= 1'b0;
      end else if (prox_done) begin
         last_judge_ff <= prox_judge;
         agree_cnt_ff <= agree_next;
      end
   end

   // interrupt status; event wins over release
   always_ff @(posedge core_clk) begin
      if (rst || restarting) begin
         prox_int_ff <= 1'b0;
         light_int_ff <= 1'b0;
      end else begin
         if (prox_done) begin
            // R15: persistence 0000 and 0001
            if (pxctl_ff[3:0] == 4'h0)
               prox_int_ff <= 1'b1;
            else if (pxctl_ff[3:0] == 4'h1)
               prox_int_ff <= prox_judge;
            // R16: N agreeing judgments
            else if (agree_next >= pxctl_ff[3:0])
               prox_int_ff <= prox_judge;
         end else if (intreg_read) begin
            prox_int_ff <= 1'b0;
         end
         // R17: light unfiltered
         if (light_done)
            light_int_ff <= light_judge;
         else if (intreg_read)
            light_int_ff <= 1'b0;
      end
   end

   // alert pin: open drain, low when driven
   always_ff @(posedge core_clk) begin
      if (rst) begin
         alert_rel_ff <= 1'b0;
      // R2: alert release
      end else if (wr && req.addr == `LPSC_OFF_SYSCTL
                   && req.wdata[`LPSC_BIT_ALERT_REL]) begin
         alert_rel_ff <= 1'b1;
      end else if (prox_done || light_done) begin
         alert_rel_ff <= 1'b0;
      end
   end
   // R18: release on read or restart
   assign alert_oe = (prox_int_ff || light_int_ff) && !alert_rel_ff
                     && !restarting;

   // register read mux
   always_ff @(posedge core_clk) begin
      if (rst) begin
         rdata_ff <= 8'h00;
      end else if (req.re) begin
         unique case (req.addr)
            `LPSC_OFF_SYSCTL: rdata_ff <= {2'b00, PART_ID};
            `LPSC_OFF_MODE: rdata_ff <= mode_ff;
            `LPSC_OFF_GAIN: rdata_ff <= gain_ff;
            `LPSC_OFF_PXCTL: rdata_ff <= {amb_ff, pxctl_ff};
            // R19: twelve bit proximity
            `LPSC_OFF_PX_LO: rdata_ff <= px_ff[7:0];
            `LPSC_OFF_PX_HI: rdata_ff <= {4'h0, px_ff[11:8]};
            // R20: sixteen bit light
            `LPSC_OFF_VIS_LO: rdata_ff <= vis_ff[7:0];
            `LPSC_OFF_VIS_HI: rdata_ff <= vis_ff[15:8];
            `LPSC_OFF_IR_LO: rdata_ff <= ir_ff[7:0];
            `LPSC_OFF_IR_HI: rdata_ff <= ir_ff[15:8];
            `LPSC_OFF_INTREG: rdata_ff <= {prox_int_ff, light_int_ff, 6'h00};
            default: rdata_ff <= 8'h00;
         endcase
      end
   end

   // assertions
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (rst);

   // cycles of the current emitter pulse
   logic [15:0] emit_len_ff;
   always_ff @(posedge core_clk) begin
      if (rst || state_ff == LPSC_IDLE)
         emit_len_ff <= 16'h0000;
      else if (emitter_oe)
         emit_len_ff <= emit_len_ff + 16'h0001;
   end

   a_restart_clears_mode: assert property ( // R1
      restart_req |=> mode_ff == `LPSC_RST_MODE)
      else $error("restart did not clear mode");
   a_restart_frees_alert: assert property ( // R18
      restarting |-> !alert_oe)
      else $error("alert driven during restart");
   a_alert_release_bit: assert property ( // R2
      (wr && req.addr == `LPSC_OFF_SYSCTL && req.wdata[6] && !req.wdata[7]
       && !prox_done && !light_done) |=> !alert_oe)
      else $error("alert not released");
   a_pulse_width_len: assert property ( // R4
      $fell(emitter_oe) && !$past(restart_req)
      |-> emit_len_ff == 16'(PULSE_SHORT_CYC)
          || emit_len_ff == 16'(PULSE_LONG_CYC))
      else $error("emitter pulse length wrong");
   a_px_high_zero: assert property ( // R19
      (req.re && req.addr == `LPSC_OFF_PX_HI) |=> rdata_ff[7:4] == 4'h0)
      else $error("proximity high nibble not zero");
   a_persist_zero: assert property ( // R15
      (prox_done && pxctl_ff[3:0] == 4'h0 && !restart_req && !restarting)
      |=> prox_int_ff)
      else $error("interrupt not set at measurement end");
   a_light_unfiltered: assert property ( // R17
      (light_done && !restart_req && !restarting)
      |=> light_int_ff == $past(light_judge))
      else $error("light interrupt filtered");
   a_gain_fields: assert property ( // R10
      (wr && req.addr == `LPSC_OFF_GAIN && !restarting) |=>
      visible_channel_gain == $past(req.wdata[5:4])
      && emitter_drive_level == $past(req.wdata[1:0]))
      else $error("gain fields not taken");
   a_enable_bits: assert property ( // R3
      (wr && req.addr == `LPSC_OFF_MODE && !restarting) |=>
      light_sensing_on == $past(req.wdata[7]))
      else $error("light enable not taken");
endmodule
`default_nettype wire

// file: tb/lpsc_host_model.sv
/*
 host side of the register port: byte writes and reads.
 assumes a rising-edge core_clk and registered read data.
*/
`timescale 1ns/1ps
`default_nettype none
module lpsc_host_model
   import lpsc_pkg::*;
(
   input wire logic core_clk,
   input wire logic [7:0] rdata_ff,
   output lpsc_req_s req
);
   initial begin
      req = '{we: 1'b0, re: 1'b0, addr: 8'h00, wdata: 8'h00};
   end
   // idle bus shows inverted lines, never a stale value
   task automatic idle();
      req <= '{we: 1'b0, re: 1'b0, addr: ~req.addr, wdata: ~req.wdata};
   endtask
   // host writes whole bytes; callers avoid forbidden codes
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge core_clk);
      req <= '{we: 1'b1, re: 1'b0, addr: a, wdata: v};
      @(posedge core_clk);
      idle();
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge core_clk);
      req <= '{we: 1'b0, re: 1'b1, addr: a, wdata: req.wdata};
      @(posedge core_clk);
      idle();
      #1;
      v = rdata_ff;
   endtask
   // 50ms pairing code gets a second confirming write
   task automatic set_mode(input logic [7:0] v);
      wr(8'h41, v);
      if (v[3:0] == 4'hC) begin
         wr(8'h41, v);
      end
   endtask
endmodule
`default_nettype wire

// file: tb/light_proximity_sensor_control_tb.sv
/*
 self-checking bench of the sensor control block.
 assumes the host model on the register port; the bench drives results.
*/
`timescale 1ns/1ps
`default_nettype none
module light_proximity_sensor_control_tb;
   import lpsc_pkg::*;
   localparam int RC = 4;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   lpsc_req_s req;
   lpsc_meas_s meas = '0;
   logic prox_done = 1'b0;
   logic light_done = 1'b0;
   logic prox_judge = 1'b0;
   logic light_judge = 1'b0;
   logic [7:0] rdata_ff;
   logic [7:0] d;
   logic [7:0] v;
   logic alert_oe, emitter_oe, emitter_out, light_sensing_on;
   logic proximity_sensing_on, twice_mode, light_sleep_phase;
   logic light_high_sens, restarting;
   logic [9:0] light_period_ms, prox_period_ms;
   logic [1:0] visible_channel_gain, infrared_channel_gain;
   logic [1:0] emitter_drive_level, proximity_gain;
   int errors = 0;
   int n_tests = 0;
   int i;
   int k;
   lpsc_meas_s m;
   // part id value is arbitrary
   lpsc_ctrl #(.RESTART_CYCLES(RC), .PULSE_SHORT_CYC(4),
      .PULSE_LONG_CYC(8), .PART_ID(6'h15)) lpsc_ctrl_inst (
      .core_clk(core_clk), .rst(rst), .req(req), .rdata_ff(rdata_ff),
      .meas(meas), .prox_done(prox_done), .prox_judge(prox_judge),
      .light_done(light_done), .light_judge(light_judge),
      .alert_oe(alert_oe), .emitter_oe(emitter_oe),
      .emitter_out(emitter_out), .light_sensing_on(light_sensing_on),
      .proximity_sensing_on(proximity_sensing_on),
      .twice_mode(twice_mode), .light_period_ms(light_period_ms),
      .prox_period_ms(prox_period_ms),
      .light_sleep_phase(light_sleep_phase),
      .light_high_sens(light_high_sens),
      .visible_channel_gain(visible_channel_gain),
      .infrared_channel_gain(infrared_channel_gain),
      .emitter_drive_level(emitter_drive_level),
      .proximity_gain(proximity_gain), .restarting(restarting));
   lpsc_host_model lpsc_host_model_inst (.core_clk(core_clk),
      .rdata_ff(rdata_ff), .req(req));
   initial begin
      forever #4 core_clk = ~core_clk;
   end
   function automatic logic [9:0] light_exp(input int c);
      case (c)
         5, 6, 7: light_exp = 10'd100;
         8, 9, 10, 11: light_exp = 10'd400;
         12: light_exp = 10'd50;
         default: light_exp = 10'd0;
      endcase
   endfunction
   function automatic logic [9:0] prox_exp(input int c);
      case (c)
         1: prox_exp = 10'd10;
         2: prox_exp = 10'd40;
         3, 6, 9: prox_exp = 10'd100;
         4, 7, 11: prox_exp = 10'd400;
         5, 8, 12: prox_exp = 10'd50;
         default: prox_exp = 10'd0;
      endcase
   endfunction
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
      lpsc_host_model_inst.rd(a, d);
      chk(d, exp);
   endtask
   task automatic pulse(input logic pj, input logic lj);
      @(posedge core_clk);
      meas <= m;
      prox_done <= 1'b1;
      light_done <= 1'b1;
      prox_judge <= pj;
      light_judge <= lj;
      @(posedge core_clk);
      prox_done <= 1'b0;
      light_done <= 1'b0;
   endtask
   task automatic test_done();
      if (errors == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   initial begin
      void'($urandom(32'had1e));
      repeat (8) @(posedge core_clk);
      rst <= 1'b0;
      rchk(8'h40, 8'h15);
      rchk(8'h41, 8'h00);
      rchk(8'h42, 8'h02);
      rchk(8'h43, 8'h01);
      for (i = 8'h44; i <= 8'h49; i++) rchk(i[7:0], 8'h00);
      rchk(8'h60, 8'h00);
      for (i = 0; i < 13; i++) begin
         v = {4'($urandom_range(15, 0)), i[3:0]};
         lpsc_host_model_inst.set_mode(v);
         @(posedge core_clk);
         #1;
         chk(light_sensing_on, v[7]);
         chk(proximity_sensing_on, v[6]);
         chk(twice_mode, v[4]);
         chk(light_period_ms, light_exp(i));
         chk(prox_period_ms, prox_exp(i));
         chk(light_high_sens, i == 10);
         chk(light_sleep_phase, i == 8 || i == 9);
         rchk(8'h41, v);
      end
      for (i = 0; i < 8; i++) begin
         v = {2'b00, i[1:0], ~i[1:0], 2'($urandom_range(3, 0))};
         lpsc_host_model_inst.wr(8'h42, v);
         #1;
         chk(visible_channel_gain, v[5:4]);
         chk(infrared_channel_gain, v[3:2]);
         chk(emitter_drive_level, v[1:0]);
         rchk(8'h42, v);
         v = {2'b00, 2'(i % 3), 4'($urandom_range(15, 0))};
         lpsc_host_model_inst.wr(8'h43, v);
         #1;
         chk(proximity_gain, v[5:4]);
         rchk(8'h43, v);
      end
      // results in low then high byte
      for (i = 0; i < 4; i++) begin
         m.visible = 16'($urandom);
         m.infrared = 16'($urandom);
         m.proximity = 12'($urandom);
         m.amb_ir = (i == 2) ? 2'b11 : i[1:0];
         lpsc_host_model_inst.wr(8'h41, {2'b11, i[0], 5'h0B});
         pulse(1'b0, 1'b0);
         k = i[0] ? ((m.proximity << 1) & 12'hFFF) : m.proximity;
         rchk(8'h44, k[7:0]);
         rchk(8'h45, {4'h0, k[11:8]});
         rchk(8'h46, m.visible[7:0]);
         rchk(8'h47, m.visible[15:8]);
         rchk(8'h48, m.infrared[7:0]);
         rchk(8'h49, m.infrared[15:8]);
         lpsc_host_model_inst.rd(8'h43, d);
         chk(d[7:6], m.amb_ir);
      end
      // three agreeing judgments before proximity status moves
      lpsc_host_model_inst.wr(8'h43, 8'h03);
      lpsc_host_model_inst.rd(8'h4A, d);
      rchk(8'h4A, 8'h00);
      pulse(1'b1, 1'b0);
      pulse(1'b1, 1'b1);
      rchk(8'h4A, 8'h40);
      pulse(1'b1, 1'b0);
      rchk(8'h4A, 8'h80);
      rchk(8'h4A, 8'h00);
      lpsc_host_model_inst.wr(8'h43, 8'h01);
      pulse(1'b1, 1'b0);
      rchk(8'h4A, 8'h80);
      lpsc_host_model_inst.wr(8'h43, 8'h00);
      pulse(1'b0, 1'b0);
      #1;
      chk(alert_oe, 1'b1);
      lpsc_host_model_inst.wr(8'h40, 8'h40);
      #1;
      chk(alert_oe, 1'b0);
      lpsc_host_model_inst.rd(8'h4A, d);
      chk(d[7], 1'b1);
      // zero does not restart, one restarts to defaults
      lpsc_host_model_inst.wr(8'h41, 8'hC3);
      lpsc_host_model_inst.wr(8'h40, 8'h00);
      #1;
      chk(restarting, 1'b0);
      pulse(1'b1, 1'b1);
      #1;
      chk(alert_oe, 1'b1);
      lpsc_host_model_inst.wr(8'h40, 8'h80);
      #1;
      chk(alert_oe, 1'b0);
      k = 0;
      while (restarting === 1'b1 && k < 50) begin
         @(posedge core_clk);
         #1;
         k++;
      end
      chk(k, RC);
      chk(alert_oe, 1'b0);
      rchk(8'h41, 8'h00);
      rchk(8'h42, 8'h02);
      rchk(8'h43, 8'h01);
      rchk(8'h4A, 8'h00);
      test_done();
   end
endmodule
`default_nettype wire
